// *** pkg/wdt_defs.vh ***
`ifndef WDT_DEFS_VH
`define WDT_DEFS_VH
// register byte offsets
`define WDT_OFS_CFG 12'h000
`define WDT_OFS_RESET_CONTROL_REG 12'h004
`define WDT_OFS_CNT 12'h008
// config word fields
`define CFG_POST_LSB 0
`define CFG_POST_MSB 3
`define CFG_PRE_BIT 4
`define CFG_WINDOW_DISABLE_CFG_BIT 6
`define CFG_HWEN_BIT 7
`define CFG_RESET 8'h4F
// reset control fields
`define RESET_CONTROL_REG_IDLE_BIT 2
`define RESET_CONTROL_REG_SLEEP_BIT 3
`define RESET_CONTROL_REG_WD_TIMEOUT_FLAG_BIT 4
`define RESET_CONTROL_REG_SWEN_BIT 5
// timing
`define LOW_POWER_RC_OSC_FREQ_KHZ 32
`define PRE_SHORT_DIV 32
`define PRE_LONG_DIV 128
`define PRE_SHORT_MAX 7'h1F
`define PRE_LONG_MAX 7'h7F
`endif

// *** logic/watchdog_timer_with_window.v ***
/*
 Windowed watchdog timer with APB register access.
 Assumes LOW_POWER_RC_OSC_CLK is a free running ~32 kHz clock, asynchronous to CORE_CLK,
 and that core event inputs are single-cycle pulses on CORE_CLK.
*/
// Summary of operation
// RULE1 - counting advances only on edges of the low-power rc oscillator
// RULE2 - rc oscillator is forced on whenever the watchdog is enabled
// RULE3 - prescaler divides by 32 or by 128 under config select
// RULE4 - prescale select 1 means divide-by-128, 0 means divide-by-32
// RULE5 - base period is 1 ms or 4 ms at nominal 32 kHz
// RULE6 - 4-bit postscale field at config bits 3..0 gives 16 ratios
// RULE7 - postscale ratio is two to the power of the field value
// RULE8 - every device reset clears counter, prescaler and postscaler
// RULE9 - completion of any clock switch clears all counts
// RULE10 - entering sleep or idle clears all counts
// RULE11 - leaving sleep or idle clears all counts again
// RULE12 - clear instruction in normal execution clears all counts
// RULE13 - enabled watchdog keeps counting in sleep and idle
// RULE14 - time-out in sleep or idle wakes the core, no reset
// RULE15 - software clears sleep and idle status flags after wake-up
// RULE16 - hardware enable bit set keeps watchdog always running
// RULE17 - with hardware enable set, clearing software enable does nothing
// RULE18 - with hardware enable clear, software enable bit 5 gates running
// RULE19 - every device reset clears the software enable bit
// RULE20 - in window mode software clears only in the final quarter
// RULE21 - early clear in window mode causes a watchdog reset
// RULE22 - time-out flag bit 4 sets on time-out and stays set
// RULE23 - software clears the time-out flag to see later events
// RULE24 - time-out in normal execution resets device and sets flag
// RULE25 - time-out at selected terminal count; window is its last quarter
`timescale 1ns/1ps
`include "wdt_defs.vh"
module watchdog_timer_with_window
#(
    parameter [7:0] CFG_DEFAULT = `CFG_RESET
)
(
    // clock and resets
    input wire CORE_CLK,
    input wire SRST,
    input wire POR_RST,
    // low-power rc oscillator
    input wire LOW_POWER_RC_OSC_CLK,
    output wire LOW_POWER_RC_OSC_FORCE_ON,
    // core events
    input wire WD_CLEAR_INSTR,
    input wire POWER_SAVE_INSTR,
    input wire POWER_SAVE_SLEEP,
    input wire CORE_WAKE,
    input wire CLOCK_SWITCH_DONE,
    // watchdog actions
    output reg WD_RESET_REQ,
    output reg WD_WAKE_REQ,
    output wire POWER_SAVE_ACTIVE,
    // apb slave
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    output wire PREADY,
    output reg [31:0] PRDATA,
    output wire PSLVERR
);

    reg low_power_rc_osc_meta;
    reg low_power_rc_osc_sync;
    reg low_power_rc_osc_prev;
    wire low_power_rc_osc_tick;

    reg [7:0] watchdog_config_word;
    reg wd_sw_enable;
    reg wd_timeout_flag;
    reg sleep_flag;
    reg idle_flag;
    reg in_power_save;

    reg [6:0] pre_count;
    reg [14:0] post_count;

    wire [3:0] wd_postscale_select;
    wire wd_prescale_select;
    wire window_disable_cfg;
    wire wd_hw_enable_cfg;
    wire wd_enabled;
    wire [6:0] pre_max;
    wire [14:0] post_max;
    wire pre_wrap;
    wire timeout;
    wire [21:0] elapsed;
    wire [22:0] post_periods;
    wire [22:0] period;
    wire [23:0] elapsed_x4;
    wire [23:0] period_x3;
    wire window_open;
    wire early_clear;
    wire count_clear;

    wire dev_reset;
    wire save_entry;
    wire save_exit;

    wire apb_setup;
    wire apb_write;
    wire addr_ok;
    wire wr_cfg;
    wire wr_reset_control_reg;

    // two flops before the edge detector; low_power_rc_osc_meta feeds only low_power_rc_osc_sync
    always @(posedge CORE_CLK)
    begin
        low_power_rc_osc_meta <= LOW_POWER_RC_OSC_CLK;
        low_power_rc_osc_sync <= low_power_rc_osc_meta;
        low_power_rc_osc_prev <= low_power_rc_osc_sync;
    end

    assign low_power_rc_osc_tick = low_power_rc_osc_sync & ~low_power_rc_osc_prev; // RULE1

    assign wd_postscale_select = watchdog_config_word[`CFG_POST_MSB:`CFG_POST_LSB];
    assign wd_prescale_select = watchdog_config_word[`CFG_PRE_BIT];
    assign window_disable_cfg = watchdog_config_word[`CFG_WINDOW_DISABLE_CFG_BIT];
    assign wd_hw_enable_cfg = watchdog_config_word[`CFG_HWEN_BIT];

    // hardware enable overrides the software bit entirely
    assign wd_enabled = wd_hw_enable_cfg | wd_sw_enable; // RULE16 RULE17 RULE18
    assign LOW_POWER_RC_OSC_FORCE_ON = wd_enabled; // RULE2 RULE17
    assign POWER_SAVE_ACTIVE = in_power_save;

    // divide-by-128 when select is set, else divide-by-32
    assign pre_max = wd_prescale_select ? `PRE_LONG_MAX : `PRE_SHORT_MAX; // RULE3 RULE4 RULE5
    assign pre_wrap = low_power_rc_osc_tick & (pre_count == pre_max);
    // postscaler terminal is 2^sel - 1 prescaler periods
    assign post_max = (15'h0001 << wd_postscale_select) - 15'h0001; // RULE6 RULE7
    assign timeout = wd_enabled & pre_wrap & (post_count == post_max); // RULE25

    // elapsed rc ticks and full period, both in rc ticks
    assign elapsed = wd_prescale_select ? {post_count, pre_count} : {2'h0, post_count, pre_count[4:0]};
    // one bit wider than elapsed: the longest setting spans 2^22 ticks
    assign post_periods = {8'h00, post_max} + 23'h000001;
    assign period = wd_prescale_select ? (post_periods << 7) : (post_periods << 5);
    assign elapsed_x4 = {elapsed, 2'h0};
    assign period_x3 = {1'h0, period} + {period, 1'h0};
    // window opens once three quarters of the period have gone by
    assign window_open = elapsed_x4 >= period_x3; // RULE25 RULE20

    assign early_clear = WD_CLEAR_INSTR & wd_enabled & ~in_power_save & ~window_disable_cfg &
        ~window_open; // RULE21

    assign dev_reset = SRST | POR_RST;
    // a second power-save instruction while asleep is ignored, not a restart
    assign save_entry = POWER_SAVE_INSTR & ~in_power_save;
    assign save_exit = in_power_save & (CORE_WAKE | timeout);

    // every source of a count restart; a disabled watchdog sits at zero
    assign count_clear = dev_reset // RULE8
        | CLOCK_SWITCH_DONE // RULE9
        | save_entry // RULE10
        | save_exit // RULE11
        | (WD_CLEAR_INSTR & ~in_power_save) // RULE12
        | ~wd_enabled;

    always @(posedge CORE_CLK)
    begin
        if (count_clear)
        begin
            pre_count <= 7'h00;
            post_count <= 15'h0000;
        end
        else if (low_power_rc_osc_tick)
        begin
            // keeps running in power save as well
            if (pre_wrap) // RULE13
            begin
                pre_count <= 7'h00;
                post_count <= (post_count == post_max) ? 15'h0000 : post_count + 15'h0001;
            end
            else
            begin
                pre_count <= pre_count + 7'h01;
            end
        end
    end

    always @(posedge CORE_CLK)
    begin
        if (SRST | POR_RST)
        begin
            in_power_save <= 1'b0;
            WD_RESET_REQ <= 1'b0;
            WD_WAKE_REQ <= 1'b0;
        end
        else
        begin
            // time-out in power save only wakes the core
            WD_WAKE_REQ <= timeout & in_power_save; // RULE14
            WD_RESET_REQ <= (timeout & ~in_power_save) | early_clear; // RULE24 RULE21
            // leaving beats a same-cycle entry request
            if (save_exit)
            begin
                in_power_save <= 1'b0;
            end
            else if (save_entry)
            begin
                in_power_save <= 1'b1;
            end
        end
    end

    assign apb_setup = PSEL & ~PENABLE;
    assign apb_write = PSEL & PENABLE & PWRITE;
    assign addr_ok = (PADDR == `WDT_OFS_CFG) | (PADDR == `WDT_OFS_RESET_CONTROL_REG) | (PADDR == `WDT_OFS_CNT);
    assign wr_cfg = apb_write & (PADDR == `WDT_OFS_CFG);
    assign wr_reset_control_reg = apb_write & (PADDR == `WDT_OFS_RESET_CONTROL_REG);
    // zero wait states: every access completes in its first access cycle
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~addr_ok;

    // config word lives through device resets, only power-on reloads it
    always @(posedge CORE_CLK)
    begin
        if (POR_RST)
        begin
            watchdog_config_word <= CFG_DEFAULT;
        end
        else if (wr_cfg)
        begin
            watchdog_config_word <= PWDATA[7:0];
        end
    end

    always @(posedge CORE_CLK)
    begin
        if (SRST | POR_RST)
        begin
            wd_sw_enable <= 1'b0; // RULE19
        end
        else if (wr_reset_control_reg)
        begin
            wd_sw_enable <= PWDATA[`RESET_CONTROL_REG_SWEN_BIT];
        end
    end

    // status flags survive device reset except power-on, so software can see the cause;
    // a hardware set in the same cycle as a software clear wins
    always @(posedge CORE_CLK)
    begin
        if (POR_RST)
        begin
            wd_timeout_flag <= 1'b0;
            sleep_flag <= 1'b0;
            idle_flag <= 1'b0;
        end
        else
        begin
            // wake-up time-outs set it too, so a watchdog wake can be told apart
            if (timeout) // RULE22 RULE24
            begin
                wd_timeout_flag <= 1'b1;
            end
            else if (wr_reset_control_reg) // RULE23
            begin
                wd_timeout_flag <= PWDATA[`RESET_CONTROL_REG_WD_TIMEOUT_FLAG_BIT];
            end
            // hardware never clears these after a wake-up
            if (save_entry & POWER_SAVE_SLEEP)
            begin
                sleep_flag <= 1'b1;
            end
            else if (wr_reset_control_reg) // RULE15
            begin
                sleep_flag <= PWDATA[`RESET_CONTROL_REG_SLEEP_BIT];
            end
            if (save_entry & ~POWER_SAVE_SLEEP)
            begin
                idle_flag <= 1'b1;
            end
            else if (wr_reset_control_reg) // RULE15
            begin
                idle_flag <= PWDATA[`RESET_CONTROL_REG_IDLE_BIT];
            end
        end
    end

    always @(posedge CORE_CLK)
    begin
        if (SRST | POR_RST)
        begin
            PRDATA <= 32'h00000000;
        end
        else if (apb_setup & ~PWRITE)
        begin
            // latched in setup so the data stands through the access phase
            case (PADDR)
                `WDT_OFS_CFG: PRDATA <= {24'h000000, watchdog_config_word};
                `WDT_OFS_RESET_CONTROL_REG: PRDATA <= {26'h0000000, wd_sw_enable, wd_timeout_flag, sleep_flag, idle_flag,
                    2'h0};
                `WDT_OFS_CNT: PRDATA <= {10'h000, post_count, pre_count};
                default: PRDATA <= 32'h00000000;
            endcase
        end
    end

endmodule // watchdog_timer_with_window

// *** dv/wdt_sva.sv ***
/* port-level checker for the windowed watchdog
   assumes it is bound to the top module, one clock domain */
`timescale 1ns/1ps
module wdt_sva (
    // clock and resets
    input wire CORE_CLK,
    input wire SRST,
    input wire POR_RST,
    // watched signals
    input wire LOW_POWER_RC_OSC_FORCE_ON,
    input wire POWER_SAVE_INSTR,
    input wire CORE_WAKE,
    input wire WD_RESET_REQ,
    input wire WD_WAKE_REQ,
    input wire POWER_SAVE_ACTIVE,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (SRST || POR_RST);
    sequence s_leave;
        ##[1:2] !POWER_SAVE_ACTIVE;
    endsequence
    a_reset_quiet: assert property (disable iff (1'b0) (SRST || POR_RST) |=> !WD_RESET_REQ && !WD_WAKE_REQ)
        else $error("action pulse in reset");
    a_wake_in_save: assert property (WD_WAKE_REQ |-> $past(POWER_SAVE_ACTIVE))
        else $error("wake outside power save");
    a_reset_normal: assert property (WD_RESET_REQ |-> !POWER_SAVE_ACTIVE)
        else $error("reset during power save");
    a_reset_one: assert property (WD_RESET_REQ |=> !WD_RESET_REQ)
        else $error("reset pulse too long");
    a_wake_leaves: assert property (WD_WAKE_REQ |-> s_leave)
        else $error("power save kept after wake");
    a_save_enter: assert property (POWER_SAVE_INSTR && !POWER_SAVE_ACTIVE |=> POWER_SAVE_ACTIVE)
        else $error("power save not entered");
    a_save_exit: assert property (CORE_WAKE && POWER_SAVE_ACTIVE |=> !POWER_SAVE_ACTIVE)
        else $error("power save not left");
    // rc force may only move on a register write or a reset
    a_force_cause: assert property ($changed(LOW_POWER_RC_OSC_FORCE_ON) |-> $past(PSEL && PENABLE && PWRITE || SRST))
        else $error("rc force changed alone");
endmodule // wdt_sva
bind watchdog_timer_with_window wdt_sva i_wdt_sva (.CORE_CLK(CORE_CLK), .SRST(SRST), .POR_RST(POR_RST),
    .LOW_POWER_RC_OSC_FORCE_ON(LOW_POWER_RC_OSC_FORCE_ON), .POWER_SAVE_INSTR(POWER_SAVE_INSTR), .CORE_WAKE(CORE_WAKE),
    .WD_RESET_REQ(WD_RESET_REQ), .WD_WAKE_REQ(WD_WAKE_REQ), .POWER_SAVE_ACTIVE(POWER_SAVE_ACTIVE),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE));

// *** dv/tb_top.sv ***
/* self-checking bench for the windowed watchdog
   assumes a fast stand-in rc clock so that time-outs stay short */
`timescale 1ns/1ps
`include "wdt_defs.vh"
`define CHK(n, e, g) begin \
    num_checks++; \
    if ((e) !== (g)) begin bad_count++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end \
end
module tb_top;
    logic clk = 0, por = 1, low_power_rc_osc = 0, psel = 0, pen = 0, pwr = 0, sleep = 0, err;
    logic [4:0] ev = 5'h10;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd;
    wire force_on, rst_req, wake_req, ps_act, pready, slverr;
    wire [31:0] prdata;
    int bad_count = 0, num_checks = 0, ticks = 0, t0, n;
    watchdog_timer_with_window i_watchdog_timer_with_window (.CORE_CLK(clk), .SRST(ev[4]), .POR_RST(por),
        .LOW_POWER_RC_OSC_CLK(low_power_rc_osc), .LOW_POWER_RC_OSC_FORCE_ON(force_on), .WD_CLEAR_INSTR(ev[0]), .POWER_SAVE_INSTR(ev[1]),
        .POWER_SAVE_SLEEP(sleep), .CORE_WAKE(ev[2]), .CLOCK_SWITCH_DONE(ev[3]), .WD_RESET_REQ(rst_req),
        .WD_WAKE_REQ(wake_req), .POWER_SAVE_ACTIVE(ps_act), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(slverr));
    initial forever #2.5 clk = ~clk;
    // rc period of 8 core cycles, odd offset keeps the phases unrelated
    initial
    begin
        #7.3;
        forever #20 low_power_rc_osc = ~low_power_rc_osc;
    end
    always @(posedge low_power_rc_osc) ticks <= ticks + 1;
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = slverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task pulse(input int k);
        @(posedge clk);
        ev[k] <= 1'b1;
        @(posedge clk);
        ev[k] <= 1'b0;
    endtask
    task wait_req;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (rst_req !== 1'b1 && wake_req !== 1'b1 && n < 25000);
    endtask
    task en_step(input logic [11:0] a, input logic [31:0] d, input logic e);
        apb(1'b1, a, d);
        @(negedge clk);
        `CHK("rc force", e, force_on)
    endtask
    // ticks are counted on the bench side, so allow one tick of sync slack
    function automatic logic near(input int p);
        return ticks - t0 + 1 >= p && ticks - t0 <= p + 1;
    endfunction
    task tally_and_finish;
        if (bad_count == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        #300000;
        bad_count++;
        tally_and_finish;
    end
    initial
    begin
        logic [7:0] cfg;
        void'($urandom(88347));
        repeat (3) @(posedge clk);
        ev[4] <= 1'b0;
        por <= 1'b0;
        apb(1'b0, `WDT_OFS_CFG, 32'h0);
        `CHK("cfg reset", 32'h4F, rd)
        apb(1'b0, 12'hFF0, 32'h0);
        `CHK("unmapped", 33'h100000000, {err, rd})
        en_step(`WDT_OFS_RESET_CONTROL_REG, 32'h20, 1'b1);
        en_step(`WDT_OFS_CFG, 32'hC0, 1'b1);
        en_step(`WDT_OFS_RESET_CONTROL_REG, 32'h0, 1'b1);
        en_step(`WDT_OFS_CFG, 32'h40, 1'b0);
        en_step(`WDT_OFS_RESET_CONTROL_REG, 32'h20, 1'b1);
        pulse(4);
        @(negedge clk);
        `CHK("sw reset", 1'b0, force_on)
        apb(1'b0, `WDT_OFS_CNT, 32'h0);
        `CHK("count after reset", 32'h0, rd)
        for (int i = 0; i < 5; i++)
        begin
            cfg = i == 0 ? 8'hC0 : 8'hC0 | 8'($urandom & 8'h13);
            apb(1'b1, `WDT_OFS_CFG, {24'h0, cfg});
            pulse(i[0] ? 3 : 0);
            t0 = ticks;
            wait_req;
            `CHK("period", 1'b1, near((cfg[4] ? `PRE_LONG_DIV : `PRE_SHORT_DIV) << cfg[3:0]))
            `CHK("reset pulse", 1'b1, rst_req)
            pulse(4);
            apb(1'b0, `WDT_OFS_RESET_CONTROL_REG, 32'h0);
            `CHK("flag kept", 32'h10, rd)
            apb(1'b1, `WDT_OFS_RESET_CONTROL_REG, 32'h0);
        end
        apb(1'b1, `WDT_OFS_CFG, 32'h80);
        for (int k = 20; k <= 28; k += 8)
        begin
            pulse(3);
            t0 = ticks;
            wait (ticks - t0 >= k);
            pulse(0);
            t0 = ticks;
            wait_req;
            `CHK("clear accepted", k > 24, ticks - t0 > 20)
            apb(1'b0, `WDT_OFS_RESET_CONTROL_REG, 32'h0);
            `CHK("flag after clear", k > 24, rd[`RESET_CONTROL_REG_WD_TIMEOUT_FLAG_BIT])
            apb(1'b1, `WDT_OFS_RESET_CONTROL_REG, 32'h0);
        end
        apb(1'b1, `WDT_OFS_CFG, 32'hC0);
        for (int s = 1; s >= 0; s--)
        begin
            sleep <= s[0];
            pulse(1);
            t0 = ticks;
            @(negedge clk);
            `CHK("save entered", 1'b1, ps_act)
            if (s == 0)
            begin
                pulse(2);
                t0 = ticks;
                @(negedge clk);
                `CHK("save left", 1'b0, ps_act)
            end
            wait_req;
            `CHK("wake not reset", s == 1, wake_req)
            `CHK("awake after", 1'b0, ps_act)
            `CHK("count in save", 1'b1, near(32))
            apb(1'b0, `WDT_OFS_RESET_CONTROL_REG, 32'h0);
            `CHK("save status", s == 1 ? 3'b110 : 3'b101, rd[4:2])
            apb(1'b1, `WDT_OFS_RESET_CONTROL_REG, 32'h0);
        end
        tally_and_finish;
    end
endmodule // tb_top
